//--- qdc_pkg.sv
// Constants, register map and decode helpers of the motion decoder
package qdc_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [11:0] OFS_ENABLE = 12'h500;
  localparam logic [11:0] OFS_LED_POLARITY = 12'h504;
  localparam logic [11:0] OFS_SMPPER = 12'h508;
  localparam logic [11:0] OFS_SAMPLE = 12'h50C;
  localparam logic [11:0] OFS_RPTPER = 12'h510;
  localparam logic [11:0] OFS_TOTAL = 12'h514;
  localparam logic [11:0] OFS_SNAP = 12'h518;
  localparam logic [11:0] OFS_DBLCNT = 12'h544;
  localparam logic [11:0] OFS_DBLSNAP = 12'h548;
  localparam logic [11:0] OFS_TASK_CLR_ALL = 12'h010;
  localparam logic [11:0] OFS_TASK_CLR_TOTAL = 12'h014;
  localparam logic [11:0] OFS_TASK_CLR_DBL = 12'h018;
  localparam logic [11:0] OFS_EVT_STATUS = 12'h100;
  localparam logic [11:0] OFS_IRQ_MASK = 12'h300;

  // ==========================================================
  // Reset values and field widths
  localparam logic [3:0] RST_SMPPER = 4'h0;
  localparam logic [3:0] RST_RPTPER = 4'h0;
  localparam logic [3:0] SMPPER_MAX = 4'hA;
  localparam int DBL_W = 4;
  localparam int RPT_CNT_W = 9;

  // ==========================================================
  // Event bits in status and mask
  localparam int EVT_SAMPLE = 0;
  localparam int EVT_REPORT = 1;
  localparam int EVT_OVERFLOW = 2;
  localparam int EVT_DOUBLE = 3;
  localparam int EVT_N = 4;

  // ==========================================================
  // Timing: shortest sample period at the 50 ns clock
  localparam int SAMPLE_BASE_US = 128;
  localparam int CLK_PERIOD_NS = 50;
  localparam int SAMPLE_BASE_CYC = SAMPLE_BASE_US * 1000 / CLK_PERIOD_NS;

  // Sample codes: difference of gray positions, 2'b10 is a double step
  localparam logic [1:0] SMP_DOUBLE = 2'h2;

  // Samples per report for a period code
  function automatic logic [RPT_CNT_W-1:0] rpt_samples(input logic [3:0] code);
    unique case (code)
      4'h0: rpt_samples = 9'h00A;
      4'h1: rpt_samples = 9'h028;
      4'h2: rpt_samples = 9'h050;
      4'h3: rpt_samples = 9'h078;
      4'h4: rpt_samples = 9'h0A0;
      4'h5: rpt_samples = 9'h0C8;
      4'h6: rpt_samples = 9'h0F0;
      4'h7: rpt_samples = 9'h118;
      4'h8: rpt_samples = 9'h001;
      default: rpt_samples = 9'h00A;
    endcase
  endfunction

  // Sample code as a register word: -1, 0, +1 or 2
  function automatic logic [31:0] smp_word(input logic [1:0] code);
    smp_word = (code == SMP_DOUBLE) ? 32'h0000_0002 : {{30{code[1]}}, code};
  endfunction

endpackage

//--- qdc_smp_if.sv
// Link between the register core and the pin sampler
`timescale 1ns/1ps
interface qdc_smp_if;
  logic enable;
  logic [3:0] period_sel;
  logic strobe;
  logic [1:0] code;

  modport sampler (input enable, input period_sel, output strobe, output code);
  modport core (output enable, output period_sel, input strobe, input code);
endinterface

//--- qdc_sampler.sv
// Phase pin synchroniser, sample timer and transition decode
`timescale 1ns/1ps
module qdc_sampler #(
  parameter int CNT_W = 22,
  parameter logic [21:0] BASE_CYC = 22'(qdc_pkg::SAMPLE_BASE_CYC)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Raw phase pins
  input wire logic pin_a,
  input wire logic pin_b,
  // Core side
  qdc_smp_if.sampler smp
);

  // ==========================================================
  // Two-stage synchronisers
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  always_ff @(posedge clk) begin
    sync1_q <= {pin_a, pin_b};
    sync2_q <= sync1_q;
  end

  // ==========================================================
  // Sample timer: period is the base period doubled per code step
  logic [CNT_W-1:0] tmr_q;
  logic [1:0] prev_q;
  logic strobe_q;
  logic [1:0] code_q;
  wire logic [3:0] sel_clamped = (smp.period_sel > qdc_pkg::SMPPER_MAX) ? qdc_pkg::SMPPER_MAX : smp.period_sel;
  wire logic [CNT_W-1:0] period_cyc = CNT_W'(BASE_CYC) << sel_clamped;
  wire logic tick = smp.enable && (tmr_q >= period_cyc - CNT_W'(1));
  // Gray position: 00, 01, 11, 10 map to 0..3
  wire logic [1:0] cur_pos = {sync2_q[1], sync2_q[1] ^ sync2_q[0]};

  always_ff @(posedge clk) begin
    if (rst) begin
      tmr_q <= '0;
      prev_q <= 2'h0;
      strobe_q <= 1'b0;
      code_q <= 2'h0;
    end else begin
      tmr_q <= (!smp.enable || tick) ? '0 : tmr_q + CNT_W'(1);
      strobe_q <= tick;
      // Position tracks while idle so the first sample sees no false step
      if (tick || !smp.enable) begin
        prev_q <= cur_pos;
      end
      if (tick) begin
        code_q <= cur_pos - prev_q;
      end
    end
  end

  assign smp.strobe = strobe_q;
  assign smp.code = code_q;

endmodule // qdc_sampler

//--- qdc_top.sv
// Motion decoder: APB registers, total, double count, reports and interrupt
`timescale 1ns/1ps
module qdc_top #(
  parameter logic [21:0] BASE_CYC = 22'(qdc_pkg::SAMPLE_BASE_CYC)
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Encoder pins
  input wire logic PHASE_A,
  input wire logic PHASE_B,
  // LED pin
  output logic LED_OUT,
  output logic LED_OE_N,
  // Pin ownership toward the GPIO mux
  output logic PINS_OWNED,
  // Interrupt
  output logic IRQ
);

  // ==========================================================
  // Sampler
  qdc_smp_if smp ();

  qdc_sampler #(
    .CNT_W(22),
    .BASE_CYC(BASE_CYC)
  ) u_sampler (
    .clk(REF_CLK),
    .rst(RST),
    .pin_a(PHASE_A),
    .pin_b(PHASE_B),
    .smp(smp)
  );

  // ==========================================================
  // Register state
  logic enable_q;
  logic led_pol_q;
  logic [3:0] smp_per_q;
  logic [3:0] rpt_per_q;
  logic [1:0] sample_q;
  logic [31:0] total_q;
  logic [31:0] total_d;
  logic [31:0] snap_q;
  logic [qdc_pkg::DBL_W-1:0] dbl_q;
  logic [qdc_pkg::DBL_W-1:0] dbl_d;
  logic [qdc_pkg::DBL_W-1:0] dbl_snap_q;
  logic [qdc_pkg::RPT_CNT_W-1:0] rpt_cnt_q;
  logic [qdc_pkg::EVT_N-1:0] status_q;
  logic [qdc_pkg::EVT_N-1:0] mask_q;
  logic [qdc_pkg::EVT_N-1:0] evt_set;

  assign smp.enable = enable_q;
  assign smp.period_sel = smp_per_q;

  // ==========================================================
  // APB decode
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  wire logic access = PSEL && PENABLE;
  wire logic done = access && pready_q;
  wire logic wr_fire = done && PWRITE;
  wire logic sel_enable = (PADDR == qdc_pkg::OFS_ENABLE);
  wire logic sel_led_polarity = (PADDR == qdc_pkg::OFS_LED_POLARITY);
  wire logic sel_smpper = (PADDR == qdc_pkg::OFS_SMPPER);
  wire logic sel_sample = (PADDR == qdc_pkg::OFS_SAMPLE);
  wire logic sel_rptper = (PADDR == qdc_pkg::OFS_RPTPER);
  wire logic sel_total = (PADDR == qdc_pkg::OFS_TOTAL);
  wire logic sel_snap = (PADDR == qdc_pkg::OFS_SNAP);
  wire logic sel_dblcnt = (PADDR == qdc_pkg::OFS_DBLCNT);
  wire logic sel_dblsnap = (PADDR == qdc_pkg::OFS_DBLSNAP);
  wire logic sel_clr_all = (PADDR == qdc_pkg::OFS_TASK_CLR_ALL);
  wire logic sel_clr_total = (PADDR == qdc_pkg::OFS_TASK_CLR_TOTAL);
  wire logic sel_clr_dbl = (PADDR == qdc_pkg::OFS_TASK_CLR_DBL);
  wire logic sel_status = (PADDR == qdc_pkg::OFS_EVT_STATUS);
  wire logic sel_mask = (PADDR == qdc_pkg::OFS_IRQ_MASK);
  // Unmapped words answer with an error and read as zero
  wire logic mapped = sel_enable || sel_led_polarity || sel_smpper || sel_sample || sel_rptper || sel_total
    || sel_snap || sel_dblcnt || sel_dblsnap || sel_clr_all || sel_clr_total || sel_clr_dbl
    || sel_status || sel_mask;

  // Read mux; task registers read as zero
  logic [31:0] rd_data;
  always_comb begin
    rd_data = 32'h0000_0000;
    if (sel_enable) begin
      rd_data = {31'h0, enable_q};
    end
    if (sel_led_polarity) begin
      rd_data = {31'h0, led_pol_q};
    end
    if (sel_smpper) begin
      rd_data = {28'h0, smp_per_q};
    end
    if (sel_sample) begin
      rd_data = qdc_pkg::smp_word(sample_q);
    end
    if (sel_rptper) begin
      rd_data = {28'h0, rpt_per_q};
    end
    if (sel_total) begin
      rd_data = total_q;
    end
    if (sel_snap) begin
      rd_data = snap_q;
    end
    if (sel_dblcnt) begin
      rd_data = {28'h0, dbl_q};
    end
    if (sel_dblsnap) begin
      rd_data = {28'h0, dbl_snap_q};
    end
    if (sel_status) begin
      rd_data = {28'h0, status_q};
    end
    if (sel_mask) begin
      rd_data = {28'h0, mask_q};
    end
  end

  // One wait state: data and error are registered with ready
  // Only the first access cycle launches an answer, so ready never stretches
  wire logic first_access = access && !pready_q;
  // Writes answer with zero data so a refused write never shows stale read data
  wire logic [31:0] prdata_d = PWRITE ? 32'h0000_0000 : rd_data;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= first_access;
      pslverr_q <= first_access && !mapped;
      if (first_access) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // ==========================================================
  // Tasks
  // Write-one strobes; a zero write does nothing
  wire logic task_clr_all = wr_fire && sel_clr_all && PWDATA[0];
  wire logic task_clr_total = wr_fire && sel_clr_total && PWDATA[0];
  wire logic task_clr_dbl = wr_fire && sel_clr_dbl && PWDATA[0];
  wire logic clr_total = task_clr_all || task_clr_total;
  wire logic clr_dbl = task_clr_all || task_clr_dbl;

  // ==========================================================
  // Control registers
  // Write strobes; writes to read-only words match none of them and fall away
  wire logic wr_enable = wr_fire && sel_enable;
  wire logic wr_led_polarity = wr_fire && sel_led_polarity;
  wire logic wr_smpper = wr_fire && sel_smpper;
  wire logic wr_rptper = wr_fire && sel_rptper;
  wire logic wr_mask = wr_fire && sel_mask;
  wire logic wr_status = wr_fire && sel_status;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      enable_q <= 1'b0;
      led_pol_q <= 1'b0;
      smp_per_q <= qdc_pkg::RST_SMPPER;
      rpt_per_q <= qdc_pkg::RST_RPTPER;
      mask_q <= '0;
    end else begin
      if (wr_enable) begin
        enable_q <= PWDATA[0];
      end
      if (wr_led_polarity) begin
        led_pol_q <= PWDATA[0];
      end
      if (wr_smpper) begin
        smp_per_q <= PWDATA[3:0];
      end
      if (wr_rptper) begin
        rpt_per_q <= PWDATA[3:0];
      end
      if (wr_mask) begin
        mask_q <= PWDATA[qdc_pkg::EVT_N-1:0];
      end
    end
  end

  // ==========================================================
  // Total and double count
  // A clear in the same cycle as a sample starts from zero so the sample survives.
  wire logic smp_valid = smp.strobe;
  wire logic is_double = smp_valid && (smp.code == qdc_pkg::SMP_DOUBLE);
  wire logic is_step = smp_valid && (smp.code != qdc_pkg::SMP_DOUBLE) && (smp.code != 2'h0);
  wire logic step_up = !smp.code[1];
  wire logic [31:0] total_base = clr_total ? 32'h0000_0000 : total_q;
  wire logic at_max = (total_base == 32'h7FFF_FFFF);
  wire logic at_min = (total_base == 32'h8000_0000);
  wire logic total_ovf = is_step && (step_up ? at_max : at_min);
  wire logic [qdc_pkg::DBL_W-1:0] dbl_base = clr_dbl ? '0 : dbl_q;
  // A double step on a saturated count is dropped and flags overflow
  wire logic dbl_ovf = is_double && (&dbl_base);
  wire logic [31:0] total_inc = total_base + 32'h0000_0001;
  wire logic [31:0] total_dec = total_base - 32'h0000_0001;

  always_comb begin
    total_d = total_base;
    if (is_step && !total_ovf) begin
      total_d = step_up ? total_inc : total_dec;
    end
  end

  always_comb begin
    dbl_d = dbl_base;
    if (is_double && !dbl_ovf) begin
      dbl_d = dbl_base + qdc_pkg::DBL_W'(1);
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      total_q <= 32'h0000_0000;
      dbl_q <= '0;
      sample_q <= 2'h0;
    end else begin
      total_q <= total_d;
      dbl_q <= dbl_d;
      if (smp_valid) begin
        sample_q <= smp.code;
      end
    end
  end

  // Snapshots take the value before this cycle's clear
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      snap_q <= 32'h0000_0000;
      dbl_snap_q <= '0;
    end else begin
      if (clr_total) begin
        snap_q <= total_q;
      end
      if (clr_dbl) begin
        dbl_snap_q <= dbl_q;
      end
    end
  end

  // ==========================================================
  // Report period
  // Interval in time is sample period times this count.
  wire logic [qdc_pkg::RPT_CNT_W-1:0] rpt_len = qdc_pkg::rpt_samples(rpt_per_q);
  wire logic [qdc_pkg::RPT_CNT_W-1:0] rpt_cnt_inc = rpt_cnt_q + qdc_pkg::RPT_CNT_W'(1);
  // A shortened period acts at once: a count already past the end closes the report
  wire logic rpt_end = smp_valid && (rpt_cnt_inc >= rpt_len);

  // Held at zero while disabled so a re-enable starts a full period
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rpt_cnt_q <= '0;
    end else if (!enable_q || rpt_end) begin
      rpt_cnt_q <= '0;
    end else if (smp_valid) begin
      rpt_cnt_q <= rpt_cnt_inc;
    end
  end

  // ==========================================================
  // Events: sticky, write one to clear, set wins
  always_comb begin
    evt_set = '0;
    evt_set[qdc_pkg::EVT_SAMPLE] = smp_valid;
    evt_set[qdc_pkg::EVT_REPORT] = rpt_end && (total_d != 32'h0000_0000);
    evt_set[qdc_pkg::EVT_OVERFLOW] = total_ovf || dbl_ovf;
    evt_set[qdc_pkg::EVT_DOUBLE] = rpt_end && (dbl_d != '0);
  end

  wire logic [qdc_pkg::EVT_N-1:0] evt_clr = wr_status ? PWDATA[qdc_pkg::EVT_N-1:0] : '0;

  // One flag per event; the set term is ORed over the cleared flag so a clear in the same cycle never hides an event
  logic [qdc_pkg::EVT_N-1:0] status_d;
  for (genvar g = 0; g < qdc_pkg::EVT_N; g++) begin : g_evt
    assign status_d[g] = evt_set[g] || (status_q[g] && !evt_clr[g]);
  end

  // Interrupt is built from the next status so it rises with its flag, not a cycle later
  wire logic [qdc_pkg::EVT_N-1:0] pending = status_d & mask_q;
  wire logic irq_d = |pending;

  logic irq_q;
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      status_q <= '0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // ==========================================================
  // Pins
  // Lit whenever the decoder runs; pre-sample LED timing is not modelled.
  logic led_q;
  logic led_oe_n_q;
  logic owned_q;
  // Enable is active low; the pad goes back to GPIO when the decoder is off
  wire logic led_d = led_pol_q;
  wire logic led_oe_n_d = !enable_q;
  wire logic owned_d = enable_q;

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      led_q <= 1'b0;
      led_oe_n_q <= 1'b1;
      owned_q <= 1'b0;
    end else begin
      led_q <= led_d;
      led_oe_n_q <= led_oe_n_d;
      owned_q <= owned_d;
    end
  end

  // ==========================================================
  // Outputs
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign LED_OUT = led_q;
  assign LED_OE_N = led_oe_n_q;
  assign PINS_OWNED = owned_q;
  assign IRQ = irq_q;

endmodule // qdc_top

//--- qdc_chk.sv
// Port assertions of the motion decoder and their bind
`timescale 1ns/1ps
module qdc_chk (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Pins and interrupt
  input wire logic LED_OUT,
  input wire logic LED_OE_N,
  input wire logic PINS_OWNED,
  input wire logic IRQ
);
  logic wr_done;
  logic rd_done;
  logic in_map;
  logic en_q;
  logic pol_q;
  logic [3:0] mask_q;

  // ==========================================================
  // Shadow of control bits, taken at completed writes
  assign wr_done = PSEL && PENABLE && PREADY && PWRITE && !PSLVERR;
  assign rd_done = PSEL && PENABLE && PREADY && !PWRITE;
  assign in_map = PADDR inside {12'h010, 12'h014, 12'h018, 12'h100, 12'h300, 12'h500, 12'h504,
                                12'h508, 12'h50C, 12'h510, 12'h514, 12'h518, 12'h544, 12'h548};

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      en_q <= 1'h0;
      pol_q <= 1'h0;
      mask_q <= 4'h0;
    end else if (wr_done) begin
      if (PADDR == qdc_pkg::OFS_ENABLE) en_q <= PWDATA[0];
      if (PADDR == qdc_pkg::OFS_LED_POLARITY) pol_q <= PWDATA[0];
      if (PADDR == qdc_pkg::OFS_IRQ_MASK) mask_q <= PWDATA[3:0];
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  sequence s_setup;
    PSEL && !PENABLE;
  endsequence
  sequence s_access;
    PSEL && PENABLE;
  endsequence

  a_ready_one_wait: assert property (s_setup ##1 s_access |-> !PREADY ##1 PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (PREADY |-> PSLVERR == !in_map)
    else $error("error flag disagrees with map");
  a_err_reads_zero: assert property (PREADY && PSLVERR |-> PRDATA == 32'h0)
    else $error("refused read not zero");
  a_ctrl_bits_narrow: assert property (rd_done && PADDR inside {12'h500, 12'h504} |-> PRDATA[31:1] == 31'h0)
    else $error("control upper bits not zero");
  a_report_sel_narrow: assert property (rd_done && PADDR == 12'h510 |-> PRDATA[31:4] == 28'h0)
    else $error("report field upper bits not zero");
  a_pins_follow_enable: assert property (en_q == $past(en_q) |-> PINS_OWNED == en_q)
    else $error("pin ownership differs from enable");
  a_oe_when_owned: assert property (LED_OE_N == !PINS_OWNED)
    else $error("led drive differs from ownership");
  a_led_polarity: assert property (PINS_OWNED && pol_q == $past(pol_q) |-> LED_OUT == pol_q)
    else $error("led level differs from polarity");
  a_irq_masked: assert property (mask_q == 4'h0 && $past(mask_q) == 4'h0 |-> !IRQ)
    else $error("interrupt with all sources masked");
endmodule // qdc_chk

bind qdc_top qdc_chk u_chk (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .LED_OUT(LED_OUT),
  .LED_OE_N(LED_OE_N), .PINS_OWNED(PINS_OWNED), .IRQ(IRQ));

//--- qdc_enc_model.sv
// Behavioural quadrature encoder driving the two phase pins
`timescale 1ns/1ps
module qdc_enc_model (
  // Clock
  input wire logic clk,
  // Phase outputs
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_q = 2'h0;

  // Gray order 00, 01, 11, 10: a single step moves one phase only
  assign phase_a = pos_q[1];
  assign phase_b = pos_q[1] ^ pos_q[0];

  // A delta of 2 flips both phases at once, a double transition
  task automatic move(input int delta);
    @(posedge clk);
    pos_q <= pos_q + 2'(delta);
  endtask
endmodule // qdc_enc_model

//--- tb_top.sv
// Self-checking bench of the motion decoder
`timescale 1ns/1ps
module tb_top;
  typedef struct packed {logic wr; logic [11:0] addr; logic [31:0] data; logic [31:0] exp; logic err;} qdc_row_t;
  localparam qdc_row_t ROWS [15] = '{
    '{1'h0, 12'h500, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h504, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h508, 32'h0, 32'h0, 1'h0}, '{1'h0, 12'h510, 32'h0, 32'h0, 1'h0},
    '{1'h0, 12'h514, 32'h0, 32'h0, 1'h0}, '{1'h1, 12'h514, 32'hFFFFFFFF, 32'h0, 1'h0},
    '{1'h0, 12'h514, 32'h0, 32'h0, 1'h0}, '{1'h1, 12'h504, 32'h1, 32'h0, 1'h0},
    '{1'h0, 12'h504, 32'h0, 32'h1, 1'h0}, '{1'h1, 12'h510, 32'hFFFFFFF7, 32'h0, 1'h0},
    '{1'h0, 12'h510, 32'h0, 32'h7, 1'h0}, '{1'h0, 12'h520, 32'h0, 32'h0, 1'h1},
    '{1'h1, 12'h520, 32'h1, 32'h0, 1'h1}, '{1'h1, 12'h300, 32'hF, 32'h0, 1'h0},
    '{1'h0, 12'h300, 32'h0, 32'hF, 1'h0}};
  logic REF_CLK = 1'h0;
  logic RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, PHASE_A, PHASE_B, LED_OUT, LED_OE_N, PINS_OWNED, IRQ;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, r, s, t, e9, e1;
  logic e;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;

  qdc_top #(.BASE_CYC(22'h8)) uut (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .PHASE_A(PHASE_A), .PHASE_B(PHASE_B), .LED_OUT(LED_OUT), .LED_OE_N(LED_OE_N), .PINS_OWNED(PINS_OWNED),
    .IRQ(IRQ));
  qdc_enc_model enc (.clk(REF_CLK), .phase_a(PHASE_A), .phase_b(PHASE_B));

  // ==========================================================
  // Clock, hang guard, shared tasks
  initial forever #25 REF_CLK = ~REF_CLK;

  always @(posedge REF_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // Entered right after an edge; one idle edge after release keeps drives apart
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd,
                     output logic er);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    // No own limit: only the global cycle guard ends a wait
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'h1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge REF_CLK);
  endtask

  // Waits for the sample event, returns status, clears the sample bit
  task automatic next_sample(output logic [31:0] st);
    int n;
    n = 0;
    @(posedge REF_CLK);
    while (IRQ !== 1'h1 && n < 200) begin
      @(posedge REF_CLK);
      n++;
    end
    if (n == 200) errors++;
    apb(1'h0, 12'h100, 32'h0, st, e);
    apb(1'h1, 12'h100, 32'h1, r, e);
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    RST <= 1'h1;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    PWRITE <= 1'h0;
    PADDR <= 12'h0;
    PWDATA <= 32'h0;
    repeat (3) @(posedge REF_CLK);
    RST <= 1'h0;
    chk({28'h0, PINS_OWNED, LED_OE_N, IRQ, PREADY}, 32'h4);
    @(posedge REF_CLK);
    for (int i = 0; i < 15; i++) begin
      apb(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, r, e);
      if (!ROWS[i].wr) chk(r, ROWS[i].exp);
      chk({31'h0, e}, {31'h0, ROWS[i].err});
    end
    // Sample every 32 cycles, 10 samples a report, only the sample event interrupts
    apb(1'h1, 12'h508, 32'h2, r, e);
    apb(1'h1, 12'h510, 32'h0, r, e);
    apb(1'h1, 12'h300, 32'h1, r, e);
    apb(1'h1, 12'h100, 32'hF, r, e);
    apb(1'h1, 12'h500, 32'h1, r, e);
    // Pin outputs settle one edge after the write lands
    @(posedge REF_CLK);
    chk({29'h0, PINS_OWNED, LED_OE_N, LED_OUT}, 32'h5);
    apb(1'h1, 12'h504, 32'h0, r, e);
    @(posedge REF_CLK);
    chk({29'h0, PINS_OWNED, LED_OE_N, LED_OUT}, 32'h4);
    next_sample(s);
    apb(1'h1, 12'h100, 32'hF, r, e);
    for (int i = 2; i <= 10; i++) begin
      enc.move(1);
      next_sample(s);
      chk({31'h0, s[1]}, {31'h0, i == 10});
    end
    // Each forward gray step of the model adds one
    apb(1'h0, 12'h514, 32'h0, t, e);
    e9 = 32'h0000_0009;
    e1 = 32'h0000_0001;
    chk(t, e9);
    apb(1'h1, 12'h010, 32'h1, r, e);
    apb(1'h0, 12'h518, 32'h0, r, e);
    chk(r, e9);
    apb(1'h0, 12'h514, 32'h0, r, e);
    chk(r, 32'h0);
    // One sample a report; a double step alone must not count as motion
    apb(1'h1, 12'h510, 32'h8, r, e);
    next_sample(s);
    apb(1'h1, 12'h100, 32'hF, r, e);
    enc.move(2);
    next_sample(s);
    chk({29'h0, s[3:1]}, 32'h4);
    apb(1'h0, 12'h514, 32'h0, r, e);
    chk(r, 32'h0);
    apb(1'h0, 12'h50C, 32'h0, r, e);
    chk(r, 32'h2);
    apb(1'h1, 12'h100, 32'hF, r, e);
    enc.move(1);
    next_sample(s);
    chk({31'h0, s[1]}, 32'h1);
    apb(1'h0, 12'h514, 32'h0, r, e);
    chk(r, e1);
    apb(1'h1, 12'h014, 32'h1, r, e);
    apb(1'h0, 12'h518, 32'h0, r, e);
    chk(r, e1);
    apb(1'h0, 12'h514, 32'h0, r, e);
    chk(r, 32'h0);
    // Double count holds the one double step until its own clear task
    apb(1'h0, 12'h544, 32'h0, r, e);
    chk(r, 32'h1);
    apb(1'h1, 12'h018, 32'h1, r, e);
    apb(1'h0, 12'h548, 32'h0, r, e);
    chk(r, 32'h1);
    apb(1'h0, 12'h544, 32'h0, r, e);
    chk(r, 32'h0);
    // Release pins, then mask, unmask and clear the pending events
    apb(1'h1, 12'h500, 32'h0, r, e);
    @(posedge REF_CLK);
    chk({30'h0, PINS_OWNED, LED_OE_N}, 32'h1);
    apb(1'h1, 12'h300, 32'h0, r, e);
    @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
    apb(1'h1, 12'h300, 32'hF, r, e);
    @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h1);
    apb(1'h1, 12'h100, 32'hF, r, e);
    @(posedge REF_CLK);
    chk({31'h0, IRQ}, 32'h0);
    tally_and_finish();
  end
endmodule // tb_top
